// ### pkg/cgx_regs.vh
// Constants for the clocked general-purpose external bus block
`ifndef CGX_REGS_VH
`define CGX_REGS_VH
// Interface mode selection value for clocked general-purpose operation
`define CGX_MODE_GP        4'h0
`define CGX_MODE_W         4
// Port-signal split selection encodings
`define CGX_SPLIT_D8A20    2'h0
`define CGX_SPLIT_D16A12   2'h1
`define CGX_SPLIT_D24A4    2'h2
`define CGX_SPLIT_D30      2'h3
// Frame length limits in bus clocks
`define CGX_FRAME_MIN      5'h01
`define CGX_FRAME_MAX      5'h1e
// Widths of the baud and port fields, depths of the request queue and data buffer
`define CGX_BAUD_W         16
`define CGX_PORT_W         32
`define CGX_WQ_DEPTH       4
`define CGX_FIFO_DEPTH     16
`endif

// ### hdl/cgx_fifo.v
// Synchronous valid/ready FIFO with parameterised width and depth
`timescale 1ns/1ps
`default_nettype none
module cgx_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    // Clock and reset
    input  wire             clk,
    input  wire             rstn,
    // Fill side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // Drain side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_reg;
    reg [AW-1:0]    rd_ptr_reg;
    reg [AW:0]      count_reg;
    wire            push;
    wire            pop;

    // Honest full and empty flags
    assign in_ready  = (count_reg != DEPTH[AW:0]);
    assign out_valid = (count_reg != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr_reg];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Pointer and count update
    always @(posedge clk) begin
        if (!rstn) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

    // Storage write
    always @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end
endmodule // cgx_fifo
`default_nettype wire

// ### hdl/cgx_ext_bus.v
// Clocked general-purpose external parallel bus engine
`timescale 1ns/1ps
`default_nettype none
`include "cgx_regs.vh"
// Contract
// - Mode field zero selects clocked general-purpose operation.
// - Frame strobe groups consecutive transactions together.
// - Frame length programmable from one to thirty.
// - Bus clock pin rate set by divider.
// - Bus clock gated or free-running, selectable.
// - Gated clock toggles only during transactions.
// - Two config words plus separate baud setting.
// - Four-word request queue stalls master only full.
module cgx_ext_bus #(
    parameter WQ_DEPTH = `CGX_WQ_DEPTH,
    parameter FQ_DEPTH = `CGX_FIFO_DEPTH
) (
    // Clock and reset
    input  wire                   clk,
    input  wire                   rstn,
    // Configuration
    input  wire [`CGX_MODE_W-1:0] interface_config_register,
    input  wire [31:0]            gp_config_reg_in,
    input  wire [31:0]            gp_config2_reg_in,
    input  wire [`CGX_BAUD_W-1:0] baud_reg_in,
    // Master request side
    input  wire                   req_valid,
    output wire                   req_ready,
    input  wire                   req_write,
    input  wire [19:0]            req_addr,
    input  wire [29:0]            req_wdata,
    // Read answer side
    output reg                    rd_valid,
    output reg  [29:0]            rd_data,
    // Status
    output wire                   busy,
    // External pins
    output reg                    bus_clk,
    output reg                    bus_frame,
    output reg                    bus_wr,
    output reg                    bus_rd,
    output reg  [29:0]            port_out,
    output reg  [29:0]            port_oe,
    input  wire [29:0]            port_in
);
    // Configuration fields: gp_config bit0 free-running clock, [2:1] split; config2 [4:0] frame length
    localparam ST_IDLE  = 3'b001;
    localparam ST_SETUP = 3'b010;
    localparam ST_XFER  = 3'b100;

    reg  [2:0]             state_reg;
    reg  [`CGX_BAUD_W-1:0] div_cnt_reg;
    reg  [4:0]             frame_cnt_reg;
    reg  [29:0]            pin_s1_reg;
    reg  [29:0]            pin_s2_reg;
    reg                    cur_write_reg;
    wire                   gp_mode;
    wire                   free_run;
    wire [1:0]             split;
    wire [4:0]             frame_len;
    wire                   tick;
    wire                   q_valid;
    wire                   q_ready;
    wire                   q_write;
    wire [19:0]            q_addr;
    wire [29:0]            q_wdata;
    wire                   wq_ready;
    wire                   wq_valid;
    wire [50:0]            wq_data;
    wire                   launch;
    wire                   xfer_end;
    wire                   chain;

    // Pack data on the lowest port signals, address above
    function [29:0] pack_port;
        input [1:0]  sp;
        input [19:0] a;
        input [29:0] d;
        begin
            case (sp)
                `CGX_SPLIT_D8A20:  pack_port = {2'b00, a, d[7:0]};
                `CGX_SPLIT_D16A12: pack_port = {2'b00, a[11:0], d[15:0]};
                `CGX_SPLIT_D24A4:  pack_port = {2'b00, a[3:0], d[23:0]};
                default:           pack_port = d;
            endcase
        end
    endfunction

    // Width mask of the data lanes for a split
    function [29:0] data_mask;
        input [1:0] sp;
        begin
            case (sp)
                `CGX_SPLIT_D8A20:  data_mask = 30'h0000_00ff;
                `CGX_SPLIT_D16A12: data_mask = 30'h0000_ffff;
                `CGX_SPLIT_D24A4:  data_mask = 30'h00ff_ffff;
                default:           data_mask = 30'h3fff_ffff;
            endcase
        end
    endfunction

    // Output enables: every lane for writes, address lanes only for reads
    function [29:0] lane_oe;
        input       w;
        input [1:0] sp;
        begin
            lane_oe = w ? 30'h3fff_ffff : (~data_mask(sp) & 30'h0fff_ffff);
        end
    endfunction

    // Configuration decode
    assign gp_mode   = (interface_config_register == `CGX_MODE_GP);
    assign free_run  = gp_config_reg_in[0];
    assign split     = gp_config_reg_in[2:1];
    assign frame_len = (gp_config2_reg_in[4:0] < `CGX_FRAME_MIN) ? `CGX_FRAME_MIN :
                       (gp_config2_reg_in[4:0] > `CGX_FRAME_MAX) ? `CGX_FRAME_MAX :
                       gp_config2_reg_in[4:0];

    // Request queue: reads and writes fill it, master stalls only when full
    assign req_ready = wq_ready;
    cgx_fifo #(.WIDTH(51), .DEPTH(WQ_DEPTH), .AW(2)) u_wq (
        .clk       (clk),
        .rstn      (rstn),
        .in_valid  (req_valid),
        .in_ready  (wq_ready),
        .in_data   ({req_write, req_addr, req_wdata}),
        .out_valid (wq_valid),
        .out_ready (q_ready),
        .out_data  (wq_data)
    );
    assign q_valid = wq_valid;
    assign {q_write, q_addr, q_wdata} = wq_data;

    // Data buffer of sixteen words between pins and the read side
    wire        rb_valid;
    wire [29:0] rb_data;
    wire        rb_ready;
    reg         rb_push;
    reg  [29:0] rb_word;
    cgx_fifo #(.WIDTH(30), .DEPTH(FQ_DEPTH), .AW(4)) u_rb (
        .clk       (clk),
        .rstn      (rstn),
        .in_valid  (rb_push),
        .in_ready  (rb_ready),
        .in_data   (rb_word),
        .out_valid (rb_valid),
        .out_ready (1'b1),
        .out_data  (rb_data)
    );

    // Read answers leave from a flop
    always @(posedge clk) begin
        if (!rstn) begin
            rd_valid <= 1'b0;
            rd_data  <= 30'h0000_0000;
        end else begin
            rd_valid <= rb_valid;
            rd_data  <= rb_data;
        end
    end

    // Baud divider: tick every baud+1 clocks, one half bus clock period
    assign tick = (div_cnt_reg == {`CGX_BAUD_W{1'b0}});
    always @(posedge clk) begin
        if (!rstn) begin
            div_cnt_reg <= {`CGX_BAUD_W{1'b0}};
        end else if (tick) begin
            div_cnt_reg <= baud_reg_in;
        end else begin
            div_cnt_reg <= div_cnt_reg - 1'b1;
        end
    end

    // Pin input synchroniser
    always @(posedge clk) begin
        if (!rstn) begin
            pin_s1_reg <= 30'h0000_0000;
            pin_s2_reg <= 30'h0000_0000;
        end else begin
            pin_s1_reg <= port_in;
            pin_s2_reg <= pin_s1_reg;
        end
    end

    // Queue pops when its head word goes onto the pins, so the head is always the next word
    assign launch   = tick && (state_reg == ST_IDLE) && gp_mode && q_valid && !bus_clk;
    assign xfer_end = tick && (state_reg == ST_XFER) && bus_clk && (cur_write_reg || rb_ready);
    assign chain    = xfer_end && (frame_cnt_reg != `CGX_FRAME_MIN) && q_valid && gp_mode;
    assign q_ready  = launch || chain;
    assign busy    = (state_reg != ST_IDLE) || q_valid;

    // Bus sequencer: setup half-clock, then one transfer per bus clock
    always @(posedge clk) begin
        if (!rstn) begin
            state_reg     <= ST_IDLE;
            bus_clk       <= 1'b0;
            bus_frame     <= 1'b0;
            bus_wr        <= 1'b0;
            bus_rd        <= 1'b0;
            port_out      <= 30'h0000_0000;
            port_oe       <= 30'h0000_0000;
            frame_cnt_reg <= 5'h00;
            cur_write_reg <= 1'b0;
            rb_push       <= 1'b0;
            rb_word       <= 30'h0000_0000;
        end else begin
            rb_push <= 1'b0;
            if (tick) begin
                // Free-running clock toggles always, gated only in ST_XFER
                if (free_run || state_reg == ST_XFER) begin
                    bus_clk <= ~bus_clk;
                end else begin
                    bus_clk <= 1'b0;
                end
                case (state_reg)
                    ST_IDLE: begin
                        if (launch) begin
                            state_reg     <= ST_SETUP;
                            cur_write_reg <= q_write;
                            port_out      <= pack_port(split, q_addr, q_wdata);
                            port_oe       <= lane_oe(q_write, split);
                            bus_wr        <= q_write;
                            bus_rd        <= ~q_write;
                            bus_frame     <= 1'b1;
                            frame_cnt_reg <= frame_len;
                        end
                    end
                    ST_SETUP: begin
                        state_reg <= ST_XFER;
                    end
                    ST_XFER: begin
                        if (xfer_end) begin
                            if (!cur_write_reg) begin
                                rb_push <= 1'b1;
                                rb_word <= pin_s2_reg & data_mask(split);
                            end
                            frame_cnt_reg <= frame_cnt_reg - 1'b1;
                            // Next queued word joins the frame while the count remains
                            if (chain) begin
                                cur_write_reg <= q_write;
                                port_out      <= pack_port(split, q_addr, q_wdata);
                                port_oe       <= lane_oe(q_write, split);
                                bus_wr        <= q_write;
                                bus_rd        <= ~q_write;
                            end else begin
                                state_reg <= ST_IDLE;
                                bus_frame <= 1'b0;
                                bus_wr    <= 1'b0;
                                bus_rd    <= 1'b0;
                                port_oe   <= 30'h0000_0000;
                            end
                        end
                    end
                    default: begin
                        state_reg <= ST_IDLE;
                    end
                endcase
            end
        end
    end
endmodule // cgx_ext_bus
`default_nettype wire

// ### verif/cgx_ext_bus_assertions.sv
// Port-level checks for the general-purpose external bus block
`timescale 1ns/1ps
`default_nettype none
module cgx_ext_bus_assertions (
    // Clock, reset and configuration
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic [3:0]  interface_config_register,
    input wire logic [31:0] gp_config_reg_in,
    input wire logic [31:0] gp_config2_reg_in,
    input wire logic [15:0] baud_reg_in,
    // Master side status
    input wire logic        req_ready,
    input wire logic        busy,
    // Bus pins
    input wire logic        bus_clk,
    input wire logic        bus_frame,
    input wire logic        bus_wr,
    input wire logic        bus_rd,
    input wire logic [29:0] port_oe
);
    logic [5:0]  n_reg;
    logic [15:0] g_reg;
    logic [4:0]  len;
    logic [4:0]  lim;
    logic [1:0]  sp;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // Clamped frame length and lane split
    assign len = gp_config2_reg_in[4:0];
    assign lim = len == 5'h00 ? 5'h01 : (len > 5'h1e ? 5'h1e : len);
    assign sp  = gp_config_reg_in[2:1];
    // Transfers in this frame, cycles since the last pin edge
    always @(posedge clk) begin
        // A rise that comes with the frame's own start is setup, not a transfer
        n_reg <= (!rstn || !bus_frame) ? 6'h00 : n_reg + {5'h00, $rose(bus_clk) && $past(bus_frame)};
        g_reg <= (!rstn || $changed(bus_clk) || $changed(bus_frame)) ? 16'h0000 : g_reg + {15'h0000, g_reg != 16'hffff};
    end
    a_mode_hold: assert property (interface_config_register != 4'h0 && !bus_frame |=> !bus_frame)
        else $error("frame began in another mode");
    a_strobe_framed: assert property (bus_wr || bus_rd |-> bus_frame)
        else $error("strobe outside frame");
    a_frame_len: assert property (n_reg <= {1'b0, lim})
        else $error("frame too long");
    a_clk_rate: assert property ($changed(bus_clk) |-> g_reg >= baud_reg_in)
        else $error("bus clock too fast");
    a_gated_idle: assert property (!gp_config_reg_in[0] && !bus_frame |-> !bus_clk)
        else $error("gated clock high when idle");
    a_write_oe: assert property (bus_wr |-> port_oe == 30'h3fff_ffff)
        else $error("write lanes not driven");
    a_read_oe: assert property (bus_rd |-> port_oe == (sp == 2'h0 ? 30'h0fff_ff00 :
        sp == 2'h1 ? 30'h0fff_0000 : sp == 2'h2 ? 30'h0f00_0000 : 30'h0000_0000))
        else $error("read lane enables wrong");
    a_full_busy: assert property ($fell(req_ready) |-> busy)
        else $error("stall while idle");
endmodule // cgx_ext_bus_assertions
`default_nettype wire

// ### verif/cgx_fpga_model.sv
// Far-side logic device answering general-purpose bus cycles
`timescale 1ns/1ps
`default_nettype none
module cgx_fpga_model (
    // Bus pins
    input wire logic        bus_clk,
    input wire logic        bus_frame,
    input wire logic        bus_wr,
    input wire logic        bus_rd,
    input wire logic [29:0] port_out,
    // Lane split in use
    input wire logic [1:0]  sp,
    // Read data back to the block
    output var logic [29:0] port_in
);
    logic [29:0] mem [0:15];
    logic [29:0] msk;
    logic [3:0]  ad;
    // Data and address lanes of the split
    always_comb begin
        msk = sp == 2'h0 ? 30'h0000_00ff : sp == 2'h1 ? 30'h0000_ffff : sp == 2'h2 ? 30'h00ff_ffff : 30'h3fff_ffff;
        ad  = sp == 2'h0 ? port_out[11:8] : sp == 2'h1 ? port_out[19:16] : sp == 2'h2 ? port_out[27:24] : 4'h0;
    end
    // Works on bus clock edges, trusts only frame and strobes; idle lanes keep changing
    initial port_in = 30'h0000_0000;
    always @(posedge bus_clk) begin
        if (bus_frame && bus_wr) mem[ad] <= port_out & msk;
        port_in <= (bus_frame && bus_rd) ? (mem[ad] | ~msk) : ~port_in;
    end
endmodule // cgx_fpga_model
`default_nettype wire

// ### verif/cgx_ext_bus_test.sv
// Self-checking bench for the general-purpose external bus block
`timescale 1ns/1ps
`default_nettype none
module cgx_ext_bus_test;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [3:0]  interface_config_register = 4'h0;
    logic [31:0] gp_config_reg_in = 32'h0000_0000;
    logic [31:0] gp_config2_reg_in = 32'h0000_0001;
    logic [15:0] baud_reg_in = 16'h0002;
    logic        req_valid = 1'b0;
    logic        req_write = 1'b0;
    logic [19:0] req_addr = 20'h0_0000;
    logic [29:0] req_wdata = 30'h0000_0000;
    wire         req_ready, rd_valid, busy, bus_clk, bus_frame, bus_wr, bus_rd;
    wire  [29:0] rd_data, port_out, port_oe, port_in;
    logic [29:0] msk [4] = '{30'h0000_00ff, 30'h0000_ffff, 30'h00ff_ffff, 30'h3fff_ffff};
    logic        full = 1'b0;
    int          err_count = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    int          fr = 0;
    int          chg = 0;
    cgx_ext_bus DUT (.clk, .rstn, .interface_config_register, .gp_config_reg_in, .gp_config2_reg_in,
        .baud_reg_in, .req_valid, .req_ready, .req_write, .req_addr, .req_wdata, .rd_valid, .rd_data,
        .busy, .bus_clk, .bus_frame, .bus_wr, .bus_rd, .port_out, .port_oe, .port_in);
    cgx_fpga_model far (.bus_clk, .bus_frame, .bus_wr, .bus_rd, .port_out, .sp(gp_config_reg_in[2:1]), .port_in);
    // Clock, watchdog and pin monitors
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (req_valid && req_ready === 1'b0) full <= 1'b1;
        if (cyc == 20000) begin
            err_count++;
            wrap_up;
        end
    end
    always @(posedge bus_frame) fr++;
    always @(bus_clk) chg++;
    task automatic wrap_up;
        if (err_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Offer one request and hold it until taken
    task automatic push(input logic w, input logic [19:0] a, input logic [29:0] d);
        req_valid <= 1'b1;
        req_write <= w;
        req_addr  <= a;
        req_wdata <= d;
        do @(posedge clk); while (req_ready !== 1'b1);
    endtask
    task automatic rd(input logic [19:0] a, input logic [29:0] e);
        push(1'b0, a, 30'h0000_0000);
        req_valid <= 1'b0;
        do @(posedge clk); while (rd_valid !== 1'b1);
        chk({2'h0, rd_data}, {2'h0, e});
    endtask
    task automatic wait_idle;
        do @(posedge clk); while (busy !== 1'b0);
    endtask
    task automatic cfg(input logic [1:0] s, input logic f, input logic [4:0] l, input logic [15:0] b);
        gp_config_reg_in  <= {29'h0, s, f};
        gp_config2_reg_in <= {27'h0, l};
        baud_reg_in       <= b;
        @(posedge clk);
    endtask
    // Every lane split: write two words, read them back
    task automatic t_splits;
        logic [29:0] a, b;
        for (int s = 0; s < 4; s++) begin
            a = 30'h2a5c_3e91 ^ s;
            b = 30'h15a3_c16e ^ s;
            cfg(s[1:0], 1'b0, 5'h04, 16'h0002);
            push(1'b1, 20'h0_0001, a);
            push(1'b1, 20'h0_0002, b);
            rd(20'h0_0001, (s == 3 ? b : a) & msk[s]);
            rd(20'h0_0002, b & msk[s]);
        end
    endtask
    // Frame grouping at several lengths, clamped ends, queue filling up
    task automatic t_frames;
        int len [4] = '{1, 2, 0, 31};
        int num [4] = '{6, 6, 6, 31};
        int nf [4] = '{6, 3, 6, 2};
        for (int i = 0; i < 4; i++) begin
            cfg(2'h1, 1'b0, len[i][4:0], 16'h0001);
            fr = 0;
            full = 1'b0;
            for (int k = 0; k < num[i]; k++) push(1'b1, 20'h0_0003, 30'h0000_1234 + k);
            req_valid <= 1'b0;
            wait_idle;
            chk(fr, nf[i]);
            chk(full, 1);
        end
    endtask
    // A request waits while another mode is selected
    task automatic t_mode;
        interface_config_register <= 4'h1;
        fr = 0;
        push(1'b1, 20'h0_0004, 30'h0000_0055);
        req_valid <= 1'b0;
        repeat (40) @(posedge clk);
        chk(fr, 0);
        chk(busy, 1);
        interface_config_register <= 4'h0;
        wait_idle;
        chk(fr, 1);
    endtask
    // Gated clock rests, free-running clock keeps its rate
    task automatic t_clock;
        chg = 0;
        repeat (40) @(posedge clk);
        chk(chg, 0);
        cfg(2'h3, 1'b1, 5'h02, 16'h0003);
        repeat (10) @(posedge clk);
        chg = 0;
        repeat (80) @(posedge clk);
        chk(chg >= 19 && chg <= 21, 1);
        push(1'b1, 20'h0_0000, 30'h1357_9bdf);
        rd(20'h0_0000, 30'h1357_9bdf);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_splits;
        t_frames;
        t_mode;
        t_clock;
        wrap_up;
    end
endmodule // cgx_ext_bus_test
bind cgx_ext_bus cgx_ext_bus_assertions sva (.clk, .rstn, .interface_config_register, .gp_config_reg_in,
    .gp_config2_reg_in, .baud_reg_in, .req_ready, .busy, .bus_clk, .bus_frame, .bus_wr, .bus_rd, .port_oe);
`default_nettype wire
